// *** rtl/mii_port_regs.vh ***
// Constants for the MII receive and transmit-error port
`ifndef MII_PORT_REGS_VH
`define MII_PORT_REGS_VH
// Mode select values
`define MODE_MII             1'b0
`define MODE_ENDEC           1'b1
// Compression control field positions
`define CTRL_POL_BIT         0
`define CTRL_MATCH_BIT       1
`define CTRL_WIDTH           2
`define CTRL_RESET           2'h0
// Frame layout, in bytes
`define DA_BYTES             6
`define DA_LAST_IDX          3'h5
`define SFD_BYTE             8'hd5
// Receive-clock edge filter: consecutive sys_clk samples per level
`define EDGE_HOLD            2'h1
`endif

// *** rtl/pin_sync.v ***
// Two-flop synchroniser with rise and fall detection on the settled level
module pin_sync #(
    parameter WIDTH = 1
) (
    input  wire             sys_clk,
    input  wire             rstn,
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] level,
    output wire [WIDTH-1:0] rise,
    output wire [WIDTH-1:0] fall
);
    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] stable;
    reg [WIDTH-1:0] prev;

    // First stage is read only by the second stage
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meta   <= {WIDTH{1'b0}};
            stable <= {WIDTH{1'b0}};
            prev   <= {WIDTH{1'b0}};
        end else begin
            meta   <= din;
            stable <= meta;
            prev   <= stable;
        end
    end

    assign level = stable;
    assign rise  = stable & ~prev;
    assign fall  = ~stable & prev;
endmodule

// *** rtl/mii_rx_port.v ***
// MII receive path, carrier sense and transmit-error / compression strobe pin
// Overview of operation
// - Transmit error output changes only on transmit clock rising edges.
// - In slow endec mode the pin strobes right after destination address arrives.
// - Strobe is asserted on address match or on no match, selectable.
// - Control input selects strobe polarity and match or no-match method.
// - Slow carrier sense marks PHY data and is used during own transmissions.
// - Receive data, valid and error sampled on rising receive clock edge.
// - Byte built from two nibbles, first nibble is the low half.
// - Slow endec mode takes serial receive data from nibble bit 0.
// - Nibbles before the start delimiter with valid high count as preamble.
// - Slow endec mode stores the valid pin as link state status bit.
// - Transmit nibbles and enable launch on rising transmit clock edge.
`include "mii_port_regs.vh"
module mii_rx_port (
    input  wire       sys_clk,
    input  wire       rstn,
    // Mode and compression control
    input  wire       endec_mode,
    input  wire [1:0] compress_ctrl,
    input  wire       cam_match,
    input  wire       cam_match_valid,
    // Pins from the PHY
    input  wire       rx_clk,
    input  wire [3:0] rx_nibble_port1,
    input  wire       rx_valid_port1,
    input  wire       rx_err,
    input  wire       carrier_sense_port1,
    input  wire       tx_clk,
    // Transmit side from the MAC core
    input  wire       tx_err_req,
    input  wire [3:0] tx_nibble_req,
    input  wire       tx_en_req,
    output reg  [3:0] tx_nibble,
    output reg        tx_en,
    output reg        tx_err_pin,
    // Receive stream to the MAC core
    output reg  [7:0] rx_byte,
    output reg        rx_byte_valid,
    output reg        rx_frame_start,
    output reg        rx_frame_end,
    output reg        rx_frame_err,
    output reg        da_done,
    output wire       carrier_sense,
    output reg        slow_endec_link_state
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    wire [8:0] sync_in;
    wire [8:0] sync_lvl;
    wire [8:0] sync_rise;
    assign sync_in = {tx_clk, rx_clk, carrier_sense_port1, rx_err, rx_valid_port1,
                      rx_nibble_port1};

    pin_sync #(.WIDTH(9)) u_sync (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .din     (sync_in),
        .level   (sync_lvl),
        .rise    (sync_rise),
        .fall    ()
    );

    wire [3:0] s_nibble = sync_lvl[3:0];
    wire       s_valid  = sync_lvl[4];
    wire       s_err    = sync_lvl[5];
    wire       rx_edge  = sync_rise[7];
    wire       tx_edge  = sync_rise[8];

    // Asynchronous carrier sense, also slow carrier sense in endec mode
    assign carrier_sense = sync_lvl[6];

    // Receive pins are delayed equally by the synchroniser, so sampling them at
    // the detected rising receive clock edge sees values set up on the falling edge.
    // ------------------------------------------------------------
    // Receive state machine
    // ------------------------------------------------------------
    localparam ST_IDLE  = 2'h0;
    localparam ST_PRE   = 2'h1;
    localparam ST_DATA  = 2'h2;

    reg  [1:0] state;
    reg  [1:0] next_state;
    reg  [3:0] low_nib;
    reg        have_low;
    reg  [2:0] byte_cnt;
    reg  [7:0] ser_shift;
    reg  [2:0] ser_cnt;
    reg        err_seen;
    reg        first_byte;

    // In endec mode the valid pin carries link state, so slow carrier sense frames
    // Limitation: a carrier drop inside a frame ends the frame there
    wire       frame_valid = endec_mode ? sync_lvl[6] : s_valid;
    wire       rx_take     = rx_edge & frame_valid;
    wire       rx_gap      = rx_edge & ~frame_valid;

    wire [7:0] nib_byte = {s_nibble, low_nib};
    wire       nib_done = have_low;
    wire [7:0] ser_byte = {s_nibble[0], ser_shift[7:1]};
    wire       ser_done = (ser_cnt == 3'h7);
    wire [7:0] cur_byte = endec_mode ? ser_byte : nib_byte;
    wire       cur_done = endec_mode ? ser_done : nib_done;
    // Delimiter searched at every nibble or bit, so any preamble length aligns
    wire       sfd_hit  = (state == ST_PRE) && (cur_byte == `SFD_BYTE);
    wire       byte_out = (state == ST_DATA) && cur_done;

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (frame_valid)
                    next_state = ST_PRE;
            end
            ST_PRE: begin
                if (!frame_valid)
                    next_state = ST_IDLE;
                else if (sfd_hit)
                    next_state = ST_DATA;
            end
            ST_DATA: begin
                if (!frame_valid)
                    next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Frame state register
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
        end else if (rx_edge) begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Nibble pairing
    // ------------------------------------------------------------
    // In MII mode low_nib holds the last nibble, which the delimiter search needs
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            low_nib  <= 4'h0;
            have_low <= 1'b0;
        end else if (rx_gap) begin
            have_low <= 1'b0;
        end else if (rx_take && !endec_mode) begin
            low_nib  <= s_nibble;
            have_low <= sfd_hit ? 1'b0 : ~have_low;
        end
    end

    // ------------------------------------------------------------
    // Serial shifter, first bit is the byte's LSB
    // ------------------------------------------------------------
    // Cleared between frames so idle line bits never fake a delimiter
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ser_shift <= 8'h00;
            ser_cnt   <= 3'h0;
        end else if (rx_gap) begin
            ser_shift <= 8'h00;
            ser_cnt   <= 3'h0;
        end else if (rx_take && endec_mode) begin
            ser_shift <= ser_byte;
            ser_cnt   <= sfd_hit ? 3'h0 : ser_cnt + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Receive error tracking
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            err_seen     <= 1'b0;
            rx_frame_err <= 1'b0;
        end else if (rx_gap) begin
            err_seen <= 1'b0;
            if (state == ST_DATA)
                rx_frame_err <= err_seen;
        end else if (rx_take && s_err) begin
            err_seen <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Endec link state
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            slow_endec_link_state <= 1'b0;
        else if (rx_edge && endec_mode)
            slow_endec_link_state <= s_valid;
    end

    // ------------------------------------------------------------
    // Byte output and frame markers
    // ------------------------------------------------------------
    // Only the first six bytes are counted; later bytes pass untouched
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            byte_cnt       <= 3'h0;
            first_byte     <= 1'b0;
            rx_byte        <= 8'h00;
            rx_byte_valid  <= 1'b0;
            rx_frame_start <= 1'b0;
            rx_frame_end   <= 1'b0;
            da_done        <= 1'b0;
        end else begin
            rx_byte_valid  <= 1'b0;
            rx_frame_start <= 1'b0;
            rx_frame_end   <= 1'b0;
            da_done        <= 1'b0;
            if (rx_gap && state == ST_DATA)
                rx_frame_end <= 1'b1;
            if (rx_take && sfd_hit) begin
                rx_frame_start <= 1'b1;
                byte_cnt       <= 3'h0;
                first_byte     <= 1'b1;
            end
            if (rx_take && byte_out) begin
                rx_byte       <= cur_byte;
                rx_byte_valid <= 1'b1;
                if (first_byte) begin
                    byte_cnt <= byte_cnt + 3'h1;
                    if (byte_cnt == `DA_LAST_IDX) begin
                        da_done    <= 1'b1;
                        first_byte <= 1'b0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Compression decision
    // ------------------------------------------------------------
    reg  compress_pending;
    reg  compress_hit;
    wire method_match = compress_ctrl[`CTRL_MATCH_BIT];
    wire active_high  = ~compress_ctrl[`CTRL_POL_BIT];
    wire strobe_level = compress_hit ? active_high : ~active_high;

    // Armed once the address is in, dropped when the frame ends
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            compress_pending <= 1'b0;
        end else if (da_done && endec_mode) begin
            compress_pending <= 1'b1;
        end else if (rx_frame_end) begin
            compress_pending <= 1'b0;
        end
    end

    // A lookup landing with the frame end still counts: set wins
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            compress_hit <= 1'b0;
        end else if (cam_match_valid && compress_pending) begin
            compress_hit <= (cam_match == method_match);
        end else if (rx_frame_end) begin
            compress_hit <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Transmit pins, on transmit clock rise
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_nibble <= 4'h0;
            tx_en     <= 1'b0;
        end else if (tx_edge) begin
            tx_nibble <= tx_nibble_req;
            tx_en     <= tx_en_req;
        end
    end

    // ------------------------------------------------------------
    // Shared pin: transmit error or compression strobe
    // ------------------------------------------------------------
    // Strobe shows its inactive level whenever no hit is pending
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_err_pin <= 1'b0;
        end else if (tx_edge) begin
            if (endec_mode)
                tx_err_pin <= strobe_level;
            else
                tx_err_pin <= tx_err_req;
        end
    end
endmodule

// *** dv/mii_rx_port_assertions.sv ***
// Port checker for the MII receive and transmit-error block
module mii_rx_port_assertions (
    input wire       sys_clk,
    input wire       rstn,
    input wire       endec_mode,
    input wire       carrier_sense_port1,
    input wire       tx_clk,
    input wire [7:0] rx_byte,
    input wire       rx_byte_valid,
    input wire       rx_frame_end,
    input wire       rx_frame_err,
    input wire       da_done,
    input wire       tx_en,
    input wire       carrier_sense,
    input wire       slow_endec_link_state
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_cs_sync; carrier_sense == $past(carrier_sense_port1, 2); endproperty
    a_cs_sync: assert property (p_cs_sync) else $error("carrier sense lag wrong");
    property p_byte_pulse; rx_byte_valid |=> !rx_byte_valid; endproperty
    a_byte_pulse: assert property (p_byte_pulse) else $error("byte strobe too long");
    property p_byte_hold; $changed(rx_byte) |-> rx_byte_valid; endproperty
    a_byte_hold: assert property (p_byte_hold) else $error("byte changed unstrobed");
    property p_end_pulse; rx_frame_end |=> !rx_frame_end; endproperty
    a_end_pulse: assert property (p_end_pulse) else $error("frame end too long");
    property p_da; da_done |-> rx_byte_valid || $past(rx_byte_valid); endproperty
    a_da: assert property (p_da) else $error("address done without byte");
    property p_err; $changed(rx_frame_err) |-> rx_frame_end; endproperty
    a_err: assert property (p_err) else $error("frame error moved mid-frame");
    property p_txen; $changed(tx_en) |-> $past(tx_clk) && $past(tx_clk, 2); endproperty
    a_txen: assert property (p_txen) else $error("tx enable off tx clock");
    property p_link; !endec_mode |=> $stable(slow_endec_link_state); endproperty
    a_link: assert property (p_link) else $error("link state moved in MII mode");
endmodule

// *** dv/phy_model.sv ***
// Behavioural PHY feeding the receive pins
module phy_model (
    output logic       rx_clk,
    output logic       tx_clk,
    output logic [3:0] rx_nibble_port1,
    output logic       rx_valid_port1,
    output logic       rx_err,
    output logic       carrier_sense_port1,
    input  logic       tx_err_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] frm [0:15];
    initial begin
        {rx_clk, rx_nibble_port1, rx_valid_port1, rx_err, carrier_sense_port1} = 8'h0;
        tx_clk = 1'b0;
        #7 forever #24 tx_clk = ~tx_clk;
    end
    always #24 rx_clk = ~rx_clk;
    // Each sampled error period stands for one invalid symbol sent
    int tx_err_periods = 0;
    always @(posedge tx_clk) if (tx_err_pin) tx_err_periods++;
    task automatic set_link(input bit up);
        @(negedge rx_clk);
        rx_valid_port1 <= up;
    endtask
    // Serial mode leaves the valid pin to the bench: it carries link state
    task automatic send(input int n, input int err_at, input bit serial);
        repeat (2) @(negedge rx_clk);
        #3 carrier_sense_port1 = 1'b1;
        for (int i = 0; i < n; i++)
            for (int k = 0; k < (serial ? 8 : 2); k++) begin
                @(negedge rx_clk);
                rx_nibble_port1 <= serial ? {3'h0, frm[i][k]} : frm[i][4*k +: 4];
                if (!serial) rx_valid_port1 <= 1'b1;
                rx_err <= !serial && i == err_at && k == 0;
            end
        @(negedge rx_clk);
        if (!serial) rx_valid_port1 <= 1'b0;
        rx_err <= 1'b0;
        rx_nibble_port1 <= ~rx_nibble_port1;
        #5 carrier_sense_port1 = 1'b0;
    endtask
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the MII receive port
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk = 0, rstn = 0, endec_mode = 0, cam_match = 0, cam_match_valid = 0;
    logic       tx_err_req = 0, tx_en_req = 0;
    logic [1:0] compress_ctrl = 2'h0;
    logic [3:0] tx_nibble_req = 4'h0;
    wire        rx_clk, tx_clk, rx_valid_port1, rx_err, carrier_sense_port1, tx_en, tx_err_pin;
    wire        rx_byte_valid, rx_frame_start, rx_frame_end, rx_frame_err, da_done;
    wire        carrier_sense, slow_endec_link_state;
    wire [3:0]  rx_nibble_port1, tx_nibble;
    wire [7:0]  rx_byte;
    int         error_cnt = 0, n_checks = 0, da_cnt = 0;
    logic [7:0] got [$];
    phy_model   phy (.*);
    mii_rx_port dut (.*);
    always #2.5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        if (rx_byte_valid === 1'b1) got.push_back(rx_byte);
        if (da_done === 1'b1) da_cnt++;
    end
    // ----------------------------------------
    // Shared checks
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] act);
        n_checks++;
        if (act !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, act);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Bounded wait; a miss ends the run
    task automatic wait_for(ref logic s, input int lim);
        for (int t = 0; t < lim && s !== 1'b1; t++) @(negedge sys_clk);
        check("wait", 8'h1, {7'h0, s});
        if (s !== 1'b1) report_and_stop();
        @(negedge sys_clk);
    endtask
    task automatic t_mii(input int err_at);
        got.delete();
        da_cnt = 0;
        phy.send(16, err_at, 0);
        wait_for(dut.rx_frame_end, 200);
        for (int j = 0; j < 8; j++) check("rx_byte", phy.frm[8+j], got[j]);
        check("da_done", 8'h1, da_cnt[7:0]);
        check("rx_frame_err", {7'h0, err_at >= 0}, {7'h0, rx_frame_err});
    endtask
    task automatic t_compress(input logic [1:0] c);
        @(negedge sys_clk);
        compress_ctrl = c;
        cam_match = c[0];
        got.delete();
        da_cnt = 0;
        fork phy.send(16, -1, 1); join_none
        wait_for(dut.da_done, 1500);
        cam_match_valid = 1'b1;
        @(negedge sys_clk);
        cam_match_valid = 1'b0;
        repeat (30) @(negedge sys_clk);
        check("strobe", {7'h0, (c[1] == c[0]) ^ c[0]}, {7'h0, tx_err_pin});
        check("serial byte", phy.frm[8], got[0]);
        wait fork;
    endtask
    task automatic t_tx;
        @(negedge sys_clk);
        {tx_en_req, tx_err_req, tx_nibble_req} = 6'h3a;
        wait_for(dut.tx_en, 40);
        check("tx_nibble", 8'h0a, {4'h0, tx_nibble});
        check("tx_err_pin", 8'h1, {7'h0, tx_err_pin});
        @(posedge tx_clk);
        @(negedge sys_clk);
        check("phy err periods", 8'h1, {7'h0, phy.tx_err_periods > 0});
        {tx_en_req, tx_err_req} = 2'h0;
    endtask
    initial begin
        for (int i = 0; i < 16; i++) phy.frm[i] = i < 7 ? 8'h55 : i == 7 ? 8'hd5 : 8'h1b * i[7:0];
        repeat (6) @(negedge sys_clk);
        rstn = 1'b1;
        t_mii(-1);
        t_mii(10);
        t_tx();
        endec_mode = 1'b1;
        phy.set_link(1'b1);
        repeat (40) @(negedge sys_clk);
        check("link", 8'h1, {7'h0, slow_endec_link_state});
        for (int c = 0; c < 4; c++) t_compress(c[1:0]);
        report_and_stop();
    end
endmodule
bind mii_rx_port mii_rx_port_assertions chk (.*);
